// ---- logic/hpspr_pkg.sv ----
// Purpose: Shared constants, layouts and types of the hot-plug slot power and reset block.
// Assumes: One 200 MHz core clock; eight downstream ports.
// Notes: All offsets, field positions, reset values and timing counts live here.
`default_nettype none

package hpspr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 8; // Downstream ports served.
  localparam int ADDR_W = 8; // Register address width.
  localparam int DATA_W = 32; // Register data width.

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00; // Configuration register.
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04; // Per-port status register.
  localparam logic [DATA_W-1:0] CONFIG_RESET = 32'h14140800; // Both delays 20, auto-off set.
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000; // Answer to unmapped reads.

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int BIT_INV_ATTN = 4; // Invert attention indicator output.
  localparam int BIT_INV_PWR_IND = 5; // Invert power indicator output.
  localparam int BIT_INV_PWR_EN = 6; // Invert slot power enable output.
  localparam int BIT_INV_ILOCK_DRV = 7; // Invert interlock drive output.
  localparam int BIT_INV_PGOOD = 8; // Invert power good input.
  localparam int PRES_LO = 9; // Presence report select, two bits.
  localparam int BIT_AUTO_OFF = 11; // Latch automatic power off.
  localparam int BIT_INV_ILOCK_ST = 12; // Invert interlock status input.
  localparam int BIT_TOGGLE = 13; // Interlock toggle mode.
  localparam int RSTM_LO = 14; // Reset source select, two bits.
  localparam int P2R_LO = 16; // Power to reset delay, eight bits.
  localparam int R2P_LO = 24; // Reset to power-off delay, eight bits.

  // ----------------------------------------------------------------
  // Status layout: four bits per port
  // ----------------------------------------------------------------
  localparam int STAT_W = 4; // Bits per port in the status register.
  localparam int STAT_PRES = 0; // Reported presence.
  localparam int STAT_RST = 1; // Port reset asserted.
  localparam int STAT_PEN = 2; // Slot power enabled.
  localparam int STAT_ILOCK = 3; // Interlock drive level before inversion.

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRES_BOTH = 2'h0,
    PRES_SIGNAL = 2'h1,
    PRES_ALWAYS = 2'h2,
    PRES_NEVER = 2'h3
  } hpspr_pres_e_t;

  localparam logic [1:0] RSTM_PWR_GOOD = 2'h1; // Reset follows power good.

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_RAMP = 2'b01,
    SEQ_ON = 2'b10,
    SEQ_DRAIN = 2'b11
  } hpspr_seq_e_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5; // Core clock period.
  localparam int TICK_PERIOD_NS = 10000000; // Timebase period, 10 ms.
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS; // Cycles per tick.
  localparam int TICK_MS = 10; // Timebase period in ms.
  localparam int ILOCK_MIN_MS = 100; // Shortest interlock pulse.
  localparam int ILOCK_MAX_MS = 150; // Longest interlock pulse.
  localparam logic [3:0] ILOCK_TICKS = 4'(ILOCK_MIN_MS / TICK_MS + 1); // Ticks per pulse.

  // Presence as reported to the hot-plug controller for one port.
  function automatic logic hpspr_presence(input logic [1:0] sel, input logic rx_det,
                                          input logic pin);
    logic res;
    res = 1'b0;
    unique case (sel)
      PRES_BOTH: res = rx_det | pin;
      PRES_SIGNAL: res = pin;
      PRES_ALWAYS: res = 1'b1;
      PRES_NEVER: res = 1'b0;
    endcase
    return res;
  endfunction

endpackage

`default_nettype wire

// ---- logic/hpspr_port_if.sv ----
// Purpose: Carries shared settings to one port sequencer and its results back.
// Assumes: Same clock on both sides.
// Notes: One instance per port.
`timescale 1ns/100ps
`default_nettype none

interface hpspr_port_if;
  logic tick; // One-cycle 10 ms timebase pulse.
  logic [7:0] p2r_delay; // Power to reset delay in ticks.
  logic [7:0] r2p_delay; // Reset to power-off delay in ticks.
  logic [1:0] rst_sel; // Reset source select.
  logic toggle_mode; // Interlock toggle mode.
  logic power_req; // Slot power wanted.
  logic power_good; // Polarity-corrected synchronised power good.
  logic ilock_cmd; // One-cycle interlock command.
  logic power_en; // Slot power enable, before inversion.
  logic port_reset; // Port reset asserted.
  logic ilock_level; // Interlock drive level, before inversion.

  // Main side drives settings and reads results.
  modport ctl (output tick, p2r_delay, r2p_delay, rst_sel, toggle_mode, power_req,
               power_good, ilock_cmd, input power_en, port_reset, ilock_level);
  // Sequencer side.
  modport seq (input tick, p2r_delay, r2p_delay, rst_sel, toggle_mode, power_req,
               power_good, ilock_cmd, output power_en, port_reset, ilock_level);
endinterface

`default_nettype wire

// ---- logic/hpspr_port_seq.sv ----
// Purpose: Power, reset and interlock sequencing of one downstream port.
// Assumes: Tick is a one-cycle pulse every 10 ms.
// Notes: Delays count whole ticks, so each wait lasts at least its programmed time.
`timescale 1ns/100ps
`default_nettype none

module hpspr_port_seq
  import hpspr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,
  // Shared settings and results.
  hpspr_port_if.seq pif
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hpspr_seq_e_t seq; // Power sequence phase.
    logic [7:0] cnt; // Delay tick count.
    logic ilock; // Interlock level.
    logic [3:0] ilock_cnt; // Interlock pulse tick count.
  } hpspr_port_state_t;

  hpspr_port_state_t st; // Registered state.
  hpspr_port_state_t next_st; // Next state.
  logic stable; // Power counts as stable.

  // Results are decoded from the registered state alone.
  assign pif.power_en = (st.seq != SEQ_OFF);
  assign pif.port_reset = (st.seq != SEQ_ON);
  assign pif.ilock_level = st.ilock;

  // Power is stable by power enable or by power good.
  always_comb
  begin
    stable = (pif.rst_sel == RSTM_PWR_GOOD) ? pif.power_good : pif.power_en;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st.seq)
      SEQ_OFF:
      begin
        // Power comes up with reset held.
        if (pif.power_req)
        begin
          next_st.seq = SEQ_RAMP;
          next_st.cnt = 8'h00;
        end
      end
      SEQ_RAMP:
      begin
        if (!pif.power_req)
        begin
          // Reset is still held in this phase, so power may drop at once.
          next_st.seq = SEQ_OFF;
        end
        else if (!stable)
        begin
          next_st.cnt = 8'h00;
        end
        else if (pif.p2r_delay == 8'h00)
        begin
          next_st.seq = SEQ_ON;
        end
        else if (pif.tick)
        begin
          // Release after delay plus one ticks: never short of the delay.
          if (st.cnt == pif.p2r_delay)
          begin
            next_st.seq = SEQ_ON;
          end
          else
          begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
      SEQ_ON:
      begin
        if (!pif.power_req)
        begin
          next_st.seq = SEQ_DRAIN;
          next_st.cnt = 8'h00;
        end
        else if (!stable)
        begin
          // Lost power good puts the port back in reset.
          next_st.seq = SEQ_RAMP;
          next_st.cnt = 8'h00;
        end
      end
      SEQ_DRAIN:
      begin
        if (pif.power_req)
        begin
          next_st.seq = SEQ_RAMP;
          next_st.cnt = 8'h00;
        end
        else if (pif.r2p_delay == 8'h00)
        begin
          next_st.seq = SEQ_OFF;
        end
        else if (pif.tick)
        begin
          if (st.cnt == pif.r2p_delay)
          begin
            next_st.seq = SEQ_OFF;
          end
          else
          begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      end
    endcase
    // Interlock: a command toggles or starts a timed pulse.
    if (pif.ilock_cmd)
    begin
      next_st.ilock = pif.toggle_mode ? ~st.ilock : 1'b1;
      next_st.ilock_cnt = 4'h0;
    end
    else if (!pif.toggle_mode && st.ilock && pif.tick)
    begin
      // The pulse ends on its eleventh tick, between 100 and 110 ms.
      if (st.ilock_cnt == ILOCK_TICKS - 4'h1)
      begin
        next_st.ilock = 1'b0;
      end
      else
      begin
        next_st.ilock_cnt = st.ilock_cnt + 4'h1;
      end
    end
  end

  // Registers the state.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st <= '{seq: SEQ_OFF, cnt: 8'h00, ilock: 1'b0, ilock_cnt: 4'h0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_zero_delay_release: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.seq == SEQ_RAMP && pif.power_req && stable && pif.p2r_delay == 8'h00)
      |=> !pif.port_reset)
    else $error("reset not released with zero delay");

  a_power_after_reset: assert property (@(posedge clk_i) disable iff (srst_i)
    $fell(pif.power_en) |-> $past(pif.port_reset))
    else $error("power dropped while reset released");

  a_ilock_toggle_flip: assert property (@(posedge clk_i) disable iff (srst_i)
    (pif.ilock_cmd && pif.toggle_mode) |=> (st.ilock != $past(st.ilock)))
    else $error("interlock did not toggle");

  a_ilock_pulse_start: assert property (@(posedge clk_i) disable iff (srst_i)
    (pif.ilock_cmd && !pif.toggle_mode) |=> st.ilock && st.ilock_cnt == 4'h0)
    else $error("interlock pulse did not start");

  a_ilock_pulse_end: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.ilock && !pif.toggle_mode && !pif.ilock_cmd && pif.tick
      && st.ilock_cnt == ILOCK_TICKS - 4'h1) |=> !st.ilock)
    else $error("interlock pulse did not end after its ticks");

endmodule

`default_nettype wire

// ---- logic/hpspr_top.sv ----
// Purpose: Hot-plug slot signal conditioning with power and reset sequencing.
// Assumes: Slot pins are asynchronous; controller signals share clk_i.
// Notes: Config at offset 0x00, per-port status at 0x04, read data one cycle later.
//
// What this block does
// - Bit 4 inverts attention indicator outputs.
// - Bit 5 inverts power indicator outputs.
// - Bit 6 inverts slot power enable outputs.
// - Bit 7 inverts interlock drive outputs.
// - Bit 8 inverts sampled power good inputs.
// - Bit 12 inverts sampled interlock status inputs.
// - Presence modes: detect OR pin, pin only.
// - Presence modes: always present, never present.
// - Open latch powers slot off when enabled.
// - Pulse mode: interlock pulse 100 to 150 ms.
// - Toggle mode: interlock command inverts output.
// - Reset follows power enable or power good.
// - Wait count times 10 ms before reset release.
// - Wait count times 10 ms before power off.
`timescale 1ns/100ps
`default_nettype none

module hpspr_top
  import hpspr_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF // Core cycles per 10 ms tick.
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic srst_i,

  // Register port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [DATA_W-1:0] rdata_o,

  // Hot-plug controller side, same clock.
  input wire logic [NUM_PORTS-1:0] attn_ind_req_i,
  input wire logic [NUM_PORTS-1:0] pwr_ind_req_i,
  input wire logic [NUM_PORTS-1:0] power_controller_ctl_i,
  input wire logic [NUM_PORTS-1:0] interlock_control_cmd_i,
  input wire logic [NUM_PORTS-1:0] latch_present_cap_i,
  input wire logic [NUM_PORTS-1:0] rx_detect_i,
  output logic [NUM_PORTS-1:0] presence_o,
  output logic [NUM_PORTS-1:0] power_good_o,
  output logic [NUM_PORTS-1:0] interlock_status_o,

  // Slot pins in.
  input wire logic [NUM_PORTS-1:0] power_good_in_i,
  input wire logic [NUM_PORTS-1:0] interlock_status_in_i,
  input wire logic [NUM_PORTS-1:0] presence_detect_in_i,
  input wire logic [NUM_PORTS-1:0] latch_open_in_i,

  // Slot pins out.
  output logic [NUM_PORTS-1:0] attn_indicator_out_o,
  output logic [NUM_PORTS-1:0] power_indicator_out_o,
  output logic [NUM_PORTS-1:0] slot_power_enable_out_o,
  output logic [NUM_PORTS-1:0] interlock_drive_out_o,
  output logic [NUM_PORTS-1:0] port_reset_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] cfg; // Configuration register.
    logic [DATA_W-1:0] rdata; // Read data, valid one cycle.

    // Pin synchronisers.
    logic [NUM_PORTS-1:0] pg_s1; // Power good, first stage.
    logic [NUM_PORTS-1:0] pg_s2; // Power good, second stage.
    logic [NUM_PORTS-1:0] ist_s1; // Interlock status, first stage.
    logic [NUM_PORTS-1:0] ist_s2; // Interlock status, second stage.
    logic [NUM_PORTS-1:0] pd_s1; // Presence pin, first stage.
    logic [NUM_PORTS-1:0] pd_s2; // Presence pin, second stage.
    logic [NUM_PORTS-1:0] lo_s1; // Latch open, first stage.
    logic [NUM_PORTS-1:0] lo_s2; // Latch open, second stage.

    // Registered outputs.
    logic [NUM_PORTS-1:0] attn; // Attention indicator pins.
    logic [NUM_PORTS-1:0] pind; // Power indicator pins.
    logic [NUM_PORTS-1:0] pen; // Power enable pins.
    logic [NUM_PORTS-1:0] ilock; // Interlock drive pins.
    logic [NUM_PORTS-1:0] prst; // Port reset outputs.
    logic [NUM_PORTS-1:0] pres; // Reported presence.
    logic [NUM_PORTS-1:0] pgood; // Corrected power good.
    logic [NUM_PORTS-1:0] ilst; // Corrected interlock status.

    // Timebase.
    logic [31:0] tb_cnt; // Timebase cycle count.
    logic tick; // Timebase pulse.
  } hpspr_top_state_t;

  hpspr_top_state_t st; // Registered state.
  hpspr_top_state_t next_st; // Next state.

  logic [NUM_PORTS-1:0] seq_pen; // Sequencer power enable.
  logic [NUM_PORTS-1:0] seq_rst; // Sequencer reset.
  logic [NUM_PORTS-1:0] seq_ilock; // Sequencer interlock level.

  logic [NUM_PORTS-1:0] power_req; // Power wanted per port.
  logic [NUM_PORTS-1:0] pgood_fix; // Polarity-corrected power good.
  logic [DATA_W-1:0] status_word; // Status register value.

  // Outputs come straight from flip-flops.
  assign rdata_o = st.rdata;
  assign presence_o = st.pres;
  assign power_good_o = st.pgood;
  assign interlock_status_o = st.ilst;

  assign attn_indicator_out_o = st.attn;
  assign power_indicator_out_o = st.pind;
  assign slot_power_enable_out_o = st.pen;
  assign interlock_drive_out_o = st.ilock;
  assign port_reset_o = st.prst;

  // ----------------------------------------------------------------
  // Per-port sequencers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    hpspr_port_if u_pif ();

    // Settings shared by every port.
    assign u_pif.tick = st.tick;
    assign u_pif.p2r_delay = st.cfg[P2R_LO +: 8];
    assign u_pif.r2p_delay = st.cfg[R2P_LO +: 8];
    assign u_pif.rst_sel = st.cfg[RSTM_LO +: 2];
    assign u_pif.toggle_mode = st.cfg[BIT_TOGGLE];

    // This port's own inputs.
    assign u_pif.power_req = power_req[p];
    assign u_pif.power_good = pgood_fix[p];
    assign u_pif.ilock_cmd = interlock_control_cmd_i[p];

    // This port's results.
    assign seq_pen[p] = u_pif.power_en;
    assign seq_rst[p] = u_pif.port_reset;
    assign seq_ilock[p] = u_pif.ilock_level;

    // One sequencer per port.
    hpspr_port_seq u_seq (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .pif(u_pif.seq)
    );
  end

  // Power request with the open-latch override.
  always_comb
  begin
    power_req = power_controller_ctl_i
              & ~({NUM_PORTS{st.cfg[BIT_AUTO_OFF]}} & latch_present_cap_i & st.lo_s2);
    // Undo the power good pin polarity.
    pgood_fix = st.pg_s2 ^ {NUM_PORTS{st.cfg[BIT_INV_PGOOD]}};
  end

  // Status word gathers each port's state.
  always_comb
  begin
    status_word = READ_ZERO;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      // One nibble per port.
      status_word[p*STAT_W + STAT_PRES] = st.pres[p];
      status_word[p*STAT_W + STAT_RST] = seq_rst[p];
      status_word[p*STAT_W + STAT_PEN] = seq_pen[p];
      status_word[p*STAT_W + STAT_ILOCK] = seq_ilock[p];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    // Two-stage synchronisers for the slot pins.
    next_st.pg_s1 = power_good_in_i;
    next_st.pg_s2 = st.pg_s1;
    next_st.ist_s1 = interlock_status_in_i;
    next_st.ist_s2 = st.ist_s1;
    next_st.pd_s1 = presence_detect_in_i;
    next_st.pd_s2 = st.pd_s1;
    next_st.lo_s1 = latch_open_in_i;
    next_st.lo_s2 = st.lo_s1;

    // Timebase: one pulse per TICK_CYCLES cycles.
    if (st.tb_cnt == 32'(TICK_CYCLES - 1))
    begin
      // Wrap and pulse once.
      next_st.tb_cnt = 32'h00000000;
      next_st.tick = 1'b1;
    end
    else
    begin
      // Count on.
      next_st.tb_cnt = st.tb_cnt + 32'h00000001;
      next_st.tick = 1'b0;
    end

    // Register writes replace the whole word.
    if (we_i && addr_i == OFF_CONFIG)
    begin
      next_st.cfg = wdata_i;
    end

    // Read data stand only in the cycle after the strobe.
    next_st.rdata = READ_ZERO;
    if (re_i)
    begin
      if (addr_i == OFF_CONFIG)
      begin
        // Configuration word.
        next_st.rdata = st.cfg;
      end
      else if (addr_i == OFF_STATUS)
      begin
        // Per-port status word.
        next_st.rdata = status_word;
      end
    end

    // Output polarity and conditioned inputs.
    next_st.attn = attn_ind_req_i ^ {NUM_PORTS{st.cfg[BIT_INV_ATTN]}};
    next_st.pind = pwr_ind_req_i ^ {NUM_PORTS{st.cfg[BIT_INV_PWR_IND]}};
    next_st.pen = seq_pen ^ {NUM_PORTS{st.cfg[BIT_INV_PWR_EN]}};
    next_st.ilock = seq_ilock ^ {NUM_PORTS{st.cfg[BIT_INV_ILOCK_DRV]}};
    next_st.prst = seq_rst;
    next_st.pgood = pgood_fix;
    next_st.ilst = st.ist_s2 ^ {NUM_PORTS{st.cfg[BIT_INV_ILOCK_ST]}};

    // Presence per port by the selected mode.
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_st.pres[p] = hpspr_presence(st.cfg[PRES_LO +: 2], rx_detect_i[p],
                                       st.pd_s2[p]);
    end
  end

  // Registers the state.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      // Ports start in reset with power off.
      st <= '0;
      st.cfg <= CONFIG_RESET;
      st.prst <= {NUM_PORTS{1'b1}};
    end
    else
    begin
      // Take the next state.
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_attn_polarity: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 attn_indicator_out_o ==
      $past(attn_ind_req_i ^ {NUM_PORTS{st.cfg[BIT_INV_ATTN]}}))
    else $error("attention indicator polarity wrong");

  a_pwr_ind_polarity: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 power_indicator_out_o ==
      $past(pwr_ind_req_i ^ {NUM_PORTS{st.cfg[BIT_INV_PWR_IND]}}))
    else $error("power indicator polarity wrong");

  a_pwr_en_polarity: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 slot_power_enable_out_o ==
      $past(seq_pen ^ {NUM_PORTS{st.cfg[BIT_INV_PWR_EN]}}))
    else $error("power enable polarity wrong");

  a_ilock_polarity: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 interlock_drive_out_o ==
      $past(seq_ilock ^ {NUM_PORTS{st.cfg[BIT_INV_ILOCK_DRV]}}))
    else $error("interlock drive polarity wrong");

  a_pres_forced: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.cfg[PRES_LO +: 2] == PRES_ALWAYS)
      |=> (presence_o == {NUM_PORTS{1'b1}}))
    else $error("forced presence not reported");

  a_latch_power_off: assert property (@(posedge clk_i) disable iff (srst_i)
    (st.cfg[BIT_AUTO_OFF] && latch_present_cap_i[0] && st.lo_s2[0])
      |=> seq_rst[0])
    else $error("open latch did not put the port in reset");

  a_config_readback: assert property (@(posedge clk_i) disable iff (srst_i)
    (re_i && addr_i == OFF_CONFIG)
      |=> (rdata_o == $past(st.cfg)))
    else $error("configuration readback wrong");

endmodule

`default_nettype wire

// ---- tb/hpspr_slot_model.sv ----
// Purpose: Behavioural slot hardware answering the block's slot pins.
// Assumes: Power good follows applied power after DLY cycles.
// Notes: Inputs and outputs are true levels; the bench applies pin polarity.
`timescale 1ns/100ps
`default_nettype none
module hpspr_slot_model
#(
  parameter int DLY = 4 // Power good lag in cycles.
)
(
  // Clock and slot inputs.
  input wire logic clk_i,
  input wire logic [7:0] pwr_i,
  input wire logic [7:0] drv_i,
  // Slot answers.
  output logic [7:0] pgood_o,
  output logic [7:0] lock_o
);
  logic [8*DLY-1:0] sh = '0; // Power history, newest in the low byte.
  // Power good rises and falls a fixed lag after power does.
  always @(posedge clk_i)
    sh <= {sh[8*DLY-9:0], pwr_i};
  assign pgood_o = sh[8*DLY-1 -: 8];
  assign lock_o = drv_i;
endmodule
`default_nettype wire

// ---- tb/test_hpspr_top.sv ----
// Purpose: Self-checking bench for the hot-plug slot power and reset block.
// Assumes: A tick of 20 cycles, so 10 ms stands for 20 cycles here.
// Notes: The slot model closes the power good and interlock status loops.
`timescale 1ns/100ps
`default_nettype none
module test_hpspr_top
  import hpspr_pkg::*;
;
  localparam int TK = 20; // Cycles per tick in this run.
  logic clk_i = 1'b0, srst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
  logic [7:0] addr_i = '0, attn_ind_req_i = '0, pwr_ind_req_i = '0, power_controller_ctl_i = '0;
  logic [7:0] interlock_control_cmd_i = '0, latch_present_cap_i = '0, rx_detect_i = '0;
  logic [7:0] presence_detect_in_i = '0, latch_open_in_i = '0, pg, lk;
  logic [31:0] wdata_i = '0, cfg = CONFIG_RESET, rdata_o;
  logic [7:0] presence_o, power_good_o, interlock_status_o, attn_indicator_out_o;
  logic [7:0] power_indicator_out_o, slot_power_enable_out_o, interlock_drive_out_o, port_reset_o;
  int n_fail = 0, n_compared = 0, cyc = 0, n;
  // Pins as the slot presents them under the current polarity setting.
  wire [7:0] power_good_in_i = pg ^ {8{cfg[8]}};
  wire [7:0] interlock_status_in_i = lk ^ {8{cfg[12]}};
  hpspr_top #(.TICK_CYCLES(TK)) dut_u (.clk_i, .srst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
    .attn_ind_req_i, .pwr_ind_req_i, .power_controller_ctl_i, .interlock_control_cmd_i,
    .latch_present_cap_i, .rx_detect_i, .presence_o, .power_good_o, .interlock_status_o,
    .power_good_in_i, .interlock_status_in_i, .presence_detect_in_i, .latch_open_in_i,
    .attn_indicator_out_o, .power_indicator_out_o, .slot_power_enable_out_o,
    .interlock_drive_out_o, .port_reset_o);
  hpspr_slot_model slot_u (.clk_i, .pwr_i(slot_power_enable_out_o ^ {8{cfg[6]}}),
    .drv_i(interlock_drive_out_o ^ {8{cfg[7]}}), .pgood_o(pg), .lock_o(lk));
  always #2.5 clk_i = ~clk_i;
  // Cuts a hung run short.
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task w(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  // One-cycle register write; the bench mirrors the configuration.
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    if (a == 8'h00)
      cfg <= d;
  endtask
  // One-cycle read; data is judged in the single cycle it stands.
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask
  task pls();
    @(posedge clk_i);
    interlock_control_cmd_i <= 8'h04;
    @(posedge clk_i);
    interlock_control_cmd_i <= 8'h00;
  endtask
  // Reset value, status at reset and unmapped place.
  task t_regs();
    rd(8'h00, 32'h14140800);
    rd(8'h04, 32'h22222222);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00000000);
  endtask
  // Output polarity bits set, then cleared.
  task t_pol();
    @(posedge clk_i);
    attn_ind_req_i <= 8'hA5;
    pwr_ind_req_i <= 8'h3C;
    wr(8'h00, CONFIG_RESET | 32'h000000F0);
    w(3);
    chk(attn_indicator_out_o, 8'h5A);
    chk(power_indicator_out_o, 8'hC3);
    chk(slot_power_enable_out_o, 8'hFF);
    chk(interlock_drive_out_o, 8'hFF);
    wr(8'h00, CONFIG_RESET);
    w(3);
    chk({attn_indicator_out_o, power_indicator_out_o, slot_power_enable_out_o,
      interlock_drive_out_o}, 32'hA53C0000);
  endtask
  // Every presence report mode.
  task t_pres();
    logic [7:0] pe [4];
    pe = '{8'h3F, 8'h0F, 8'hFF, 8'h00};
    @(posedge clk_i);
    presence_detect_in_i <= 8'h0F;
    rx_detect_i <= 8'h33;
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, CONFIG_RESET | (s << 9));
      w(5);
      chk(presence_o, pe[s]);
    end
  endtask
  // Power up and down on port 0 with short delays, then an opened latch.
  task t_seq();
    wr(8'h00, 32'h01024900);
    @(posedge clk_i);
    power_controller_ctl_i <= 8'h01;
    n = 0;
    w(3);
    chk(slot_power_enable_out_o, 8'h01);
    while (port_reset_o[0] !== 1'b0 && n < 300)
    begin
      w(1);
      n++;
    end
    chk(n >= 45 && n <= 72, 1'b1);
    chk({power_good_o, port_reset_o}, 16'h01FE);
    @(posedge clk_i);
    power_controller_ctl_i <= 8'h00;
    w(3);
    chk({slot_power_enable_out_o, port_reset_o}, 16'h01FF);
    n = 0;
    while (slot_power_enable_out_o[0] !== 1'b0 && n < 300)
    begin
      w(1);
      n++;
    end
    chk(n >= 17 && n <= 40, 1'b1);
    @(posedge clk_i);
    latch_present_cap_i <= 8'h01;
    power_controller_ctl_i <= 8'h01;
    w(90);
    chk(port_reset_o[0], 1'b0);
    @(posedge clk_i);
    latch_open_in_i <= 8'h01;
    w(55);
    chk({slot_power_enable_out_o, port_reset_o}, 16'h00FF);
    @(posedge clk_i);
    power_controller_ctl_i <= 8'h00;
    latch_open_in_i <= 8'h00;
  endtask
  // Zero delays: reset follows power enable at once.
  task t_zero();
    wr(8'h00, 32'h00000000);
    @(posedge clk_i);
    power_controller_ctl_i <= 8'h01;
    w(4);
    chk({slot_power_enable_out_o, port_reset_o}, 16'h01FE);
    @(posedge clk_i);
    power_controller_ctl_i <= 8'h00;
    w(4);
    chk({slot_power_enable_out_o, port_reset_o}, 16'h00FF);
  endtask
  // Interlock pulse width, inverted status pin, then toggle mode.
  task t_lock();
    wr(8'h00, 32'h14141800);
    pls();
    w(3);
    chk(interlock_drive_out_o, 8'h04);
    w(4);
    chk(interlock_status_o, 8'h04);
    w(180);
    chk(interlock_drive_out_o, 8'h04);
    w(120);
    chk(interlock_drive_out_o, 8'h00);
    wr(8'h00, 32'h14143800);
    pls();
    w(3);
    chk(interlock_drive_out_o, 8'h04);
    pls();
    w(3);
    chk(interlock_drive_out_o, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_pol();
    t_pres();
    t_seq();
    t_zero();
    t_lock();
    end_of_test();
  end
endmodule
`default_nettype wire
